// >>> slis_host_model.sv
`timescale 1ns/1ps
// Host software side: bus master and the interrupt service walk
module slis_host_model import slis_pkg::*; (
  // Clock
  input wire logic clk,
  // Bus answer
  input wire logic [31:0] avReadData,
  input wire logic avWaitRequest,
  // Bus request
  output slis_avreq_t avReq
);
  // Idle request from time zero
  initial avReq = '0;

  // One word transfer, held until waitrequest is seen low
  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    avReq <= '{address: a, read: !w, write: w, writedata: d,
               byteenable: 4'hf};
    // Read at the edge, before the slave's registers update, so the
    // values seen are those the slave showed in the cycle just ended.
    // No own limit: only the bench's hang guard ends a stuck wait.
    do begin
      @(posedge clk);
    end while (avWaitRequest !== 1'b0);
    // Data taken and request released at the accepting edge only
    q = avReadData;
    avReq <= '0;
  endtask

  // Service walk: type word first, then only the words it flags
  task automatic service(output logic [31:0] abn [NUM_AXES],
                         output logic [31:0] evt [NUM_AXES]);
    logic [31:0] t;
    logic [7:0] b;
    for (int a = 0; a < NUM_AXES; a++) begin
      abn[a] = '0;
      evt[a] = '0;
      b = 8'(a << AXIS_SHIFT);
      xfer(b | 8'(OFF_TYPE), 1'b0, '0, t);
      // Reading a flagged word also clears it
      if (t[TYPE_ABN_BIT]) xfer(b | 8'(OFF_ABN), 1'b0, '0, abn[a]);
      if (t[TYPE_EVT_BIT]) xfer(b | 8'(OFF_EVT), 1'b0, '0, evt[a]);
    end
  endtask
endmodule

// >>> slis_pkg.sv
package slis_pkg;
  // Axis count and register map (byte addresses, one word each)
  localparam int NUM_AXES = 4;
  localparam int AXIS_SHIFT = 5;
  localparam logic [4:0] OFF_POS_LIM = 5'h00;
  localparam logic [4:0] OFF_NEG_LIM = 5'h04;
  localparam logic [4:0] OFF_CTRL = 5'h08;
  localparam logic [4:0] OFF_FACTOR = 5'h0c;
  localparam logic [4:0] OFF_ABN = 5'h10;
  localparam logic [4:0] OFF_EVT = 5'h14;
  localparam logic [4:0] OFF_TYPE = 5'h18;
  localparam logic [7:0] OFF_INT_EN = 8'h80;
  // Control and type word field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_DECEL_BIT = 1;
  localparam int TYPE_ABN_BIT = 0;
  localparam int TYPE_EVT_BIT = 1;
  // Abnormal-stop status bit positions set inside this block
  localparam int ABN_SOFT_POS = 0;
  localparam int ABN_SOFT_NEG = 1;
  localparam int ABN_END_POS = 5;
  localparam int ABN_END_NEG = 6;
  localparam int ABN_ALARM = 7;
  localparam int ABN_SYNC_STOP = 8;
  localparam int ABN_EMG = 9;
  // Motion-event status bit positions set inside this block
  localparam int EVT_SOFT_POS = 8;
  localparam int EVT_SOFT_NEG = 9;
  localparam int EVT_LATCH = 14;
  localparam int EVT_ORIGIN = 15;
  localparam int EVT_SLOW = 16;
  localparam int EVT_SYNC_START = 19;
  // Bits the motion core may raise, and all defined bits
  localparam logic [31:0] ABN_CORE = 32'h0003_f408;
  localparam logic [31:0] ABN_VALID = 32'h0003_f7eb;
  localparam logic [31:0] EVT_CORE = 32'h8000_1cf7;
  localparam logic [31:0] EVT_VALID = 32'h8009_dff7;
  // Values after reset
  localparam logic [31:0] RST_LIMIT = 32'h0000_0000;
  localparam logic [31:0] RST_FACTOR = 32'h0000_0000;
  localparam logic [31:0] RST_STATUS = 32'h0000_0000;
  // Only these axes own a latch input
  localparam logic [3:0] LATCH_AXES = 4'hc;

  typedef logic signed [31:0] slis_pos_t;

  // Pin group of one axis
  typedef struct packed {
    logic endTravelLimitPos;
    logic endTravelLimitNeg;
    logic servoAlarmInput;
    logic synchronousStopInput;
    logic emergencyStopInput;
    logic slowDownInput;
    logic synchronousStartInput;
    logic originHomeInput;
    logic latchInput;
  } slis_pins_t;

  // Avalon-MM request from the master
  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } slis_avreq_t;

  // Per-axis state
  typedef struct packed {
    slis_pos_t posLim;
    slis_pos_t negLim;
    logic limEn;
    logic decelReact;
    logic [31:0] factor;
    logic [31:0] abn;
    logic [31:0] evt;
    logic posHit;
    logic negHit;
    slis_pins_t pinPrev;
    logic stopNow;
    logic stopDecel;
  } slis_axis_t;
endpackage

// >>> slis_soft_limit_int.sv
// The Avalon-MM interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// - Two soft limits per axis on command position.
// - Limit hit stops now or decelerates.
// - Feedback position never used for soft limits.
// - Soft limit enable per axis; limits always loadable.
// - Global service enable gates the one interrupt.
// - Two status words per axis: abnormal, event.
// - Event bits individually maskable by factor register.
// - Abnormal-stop bits are never masked.
// - Soft, comparator, end limit, alarm stops flagged.
// - Sync stop, emergency, slow-down stops flagged.
// - Interpolation, buffer, counter, signal errors flagged.
// - Stop, command and ramp events flagged.
// - Soft limit and comparator matches flagged.
// - Latch on axes two, three; origin latch.
// - Slow-down and sync start flagged; reserved stay clear.
// - Continuous-motion stop interrupt flagged at bit 31.
module slis_soft_limit_int import slis_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Avalon-MM slave
  input wire slis_avreq_t avReq,
  output logic [31:0] avReadData,
  output logic avWaitRequest,
  // Motion core, same clock: command counters and events
  input wire slis_pos_t cmdPos [NUM_AXES],
  input wire logic [31:0] coreAbn [NUM_AXES],
  input wire logic [31:0] coreEvt [NUM_AXES],
  // Axis pins, asynchronous
  input wire slis_pins_t [NUM_AXES-1:0] pinRaw,
  // Stop requests to the pulse generator
  output logic [NUM_AXES-1:0] stopNow,
  output logic [NUM_AXES-1:0] stopDecel,
  // Interrupt to the host
  output logic irq
);
  typedef struct packed {
    slis_axis_t [NUM_AXES-1:0] ax;
    logic intEn;      // interrupt_service_enable
    logic waitReq;
    logic [31:0] rdata;
    logic irq;
  } slis_state_t;

  slis_state_t q;
  slis_state_t d;
  slis_pins_t [NUM_AXES-1:0] pinSync; // Synchronised pins
  logic [31:0] setA [NUM_AXES];       // Abnormal bits set this cycle
  logic [31:0] setE [NUM_AXES];       // Event bits set this cycle
  logic take;                         // Bus request completes now

  // Pins cross into this clock before any logic looks at them
  slis_sync #(.W(NUM_AXES * $bits(slis_pins_t))) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .din(pinRaw),
    .dout(pinSync)
  );

  // Axis register decode, shared by write, clear and read paths
  function automatic logic regHit(logic [7:0] adr, int a,
                                  logic [4:0] off);
    return adr == {3'(a), off};
  endfunction

  // Byte-lane merge for writes
  function automatic logic [31:0] beMerge(logic [31:0] old,
      logic [31:0] wd, logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Pending sources of one axis: abnormal always, events masked
  function automatic logic [1:0] axPend(slis_axis_t x);
    logic [1:0] p;
    p = '0;
    p[TYPE_ABN_BIT] = |x.abn;
    p[TYPE_EVT_BIT] = |(x.evt & x.factor);
    return p;
  endfunction

  // Read multiplexer; unmapped addresses read as zero
  function automatic logic [31:0] readMux(slis_state_t s,
                                          logic [7:0] adr);
    logic [31:0] r;
    r = '0;
    for (int a = 0; a < NUM_AXES; a++) begin
      if (regHit(adr, a, OFF_POS_LIM)) begin
        r = s.ax[a].posLim;
      end
      if (regHit(adr, a, OFF_NEG_LIM)) begin
        r = s.ax[a].negLim;
      end
      if (regHit(adr, a, OFF_CTRL)) begin
        r[CTRL_EN_BIT] = s.ax[a].limEn;
        r[CTRL_DECEL_BIT] = s.ax[a].decelReact;
      end
      if (regHit(adr, a, OFF_FACTOR)) begin
        r = s.ax[a].factor;
      end
      if (regHit(adr, a, OFF_ABN)) begin
        r = s.ax[a].abn;
      end
      if (regHit(adr, a, OFF_EVT)) begin
        r = s.ax[a].evt;
      end
      if (regHit(adr, a, OFF_TYPE)) begin
        r[1:0] = axPend(s.ax[a]);
      end
    end
    if (adr == OFF_INT_EN) begin
      r[0] = s.intEn;
    end
    return r;
  endfunction

  // Next-state logic for bus, limits, status and interrupt
  always_comb begin
    logic req;
    logic wr;
    logic rd;
    logic hitP;
    logic hitN;
    logic riseP;
    logic riseN;
    logic pend;
    slis_pins_t rise;
    logic [31:0] clrA;
    logic [31:0] clrE;
    req = avReq.read | avReq.write;
    wr = 1'b0;
    rd = 1'b0;
    hitP = 1'b0;
    hitN = 1'b0;
    riseP = 1'b0;
    riseN = 1'b0;
    pend = 1'b0;
    rise = '0;
    clrA = '0;
    clrE = '0;
    d = q;
    // One wait cycle, then the answer for exactly one edge
    take = req & ~q.waitReq;
    d.waitReq = ~(req & q.waitReq);
    if (req && q.waitReq && avReq.read) begin
      d.rdata = readMux(q, avReq.address);
    end
    wr = take & avReq.write;
    rd = take & avReq.read;
    if (wr && avReq.address == OFF_INT_EN && avReq.byteenable[0]) begin
      d.intEn = avReq.writedata[0];
    end
    for (int a = 0; a < NUM_AXES; a++) begin
      // Compare only the command counter, never feedback
      hitP = q.ax[a].limEn && cmdPos[a] >= q.ax[a].posLim;
      hitN = q.ax[a].limEn && cmdPos[a] <= q.ax[a].negLim;
      riseP = hitP & ~q.ax[a].posHit;
      riseN = hitN & ~q.ax[a].negHit;
      d.ax[a].posHit = hitP;
      d.ax[a].negHit = hitN;
      // Stop kind follows the per-axis reaction setting
      d.ax[a].stopNow = (riseP | riseN) & ~q.ax[a].decelReact;
      d.ax[a].stopDecel = (riseP | riseN) & q.ax[a].decelReact;
      // Edge detect on already synchronised pins
      rise = pinSync[a] & ~q.ax[a].pinPrev;
      d.ax[a].pinPrev = pinSync[a];
      // Abnormal-stop sources; core bits outside its set are dropped
      setA[a] = coreAbn[a] & ABN_CORE;
      setA[a][ABN_SOFT_POS] = riseP;
      setA[a][ABN_SOFT_NEG] = riseN;
      setA[a][ABN_END_POS] = rise.endTravelLimitPos;
      setA[a][ABN_END_NEG] = rise.endTravelLimitNeg;
      setA[a][ABN_ALARM] = rise.servoAlarmInput;
      setA[a][ABN_SYNC_STOP] = rise.synchronousStopInput;
      setA[a][ABN_EMG] = rise.emergencyStopInput;
      // Normal events; reserved positions can never be set
      setE[a] = coreEvt[a] & EVT_CORE;
      setE[a][EVT_SOFT_POS] = riseP;
      setE[a][EVT_SOFT_NEG] = riseN;
      setE[a][EVT_LATCH] = rise.latchInput & LATCH_AXES[a];
      setE[a][EVT_ORIGIN] = rise.originHomeInput;
      setE[a][EVT_SLOW] = rise.slowDownInput;
      setE[a][EVT_SYNC_START] = rise.synchronousStartInput;
      // Register writes; limits load regardless of enable
      if (wr && regHit(avReq.address, a, OFF_POS_LIM)) begin
        d.ax[a].posLim = beMerge(q.ax[a].posLim, avReq.writedata,
                                 avReq.byteenable);
      end
      if (wr && regHit(avReq.address, a, OFF_NEG_LIM)) begin
        d.ax[a].negLim = beMerge(q.ax[a].negLim, avReq.writedata,
                                 avReq.byteenable);
      end
      if (wr && regHit(avReq.address, a, OFF_CTRL) &&
          avReq.byteenable[0]) begin
        d.ax[a].limEn = avReq.writedata[CTRL_EN_BIT];
        d.ax[a].decelReact = avReq.writedata[CTRL_DECEL_BIT];
      end
      if (wr && regHit(avReq.address, a, OFF_FACTOR)) begin
        d.ax[a].factor = beMerge(q.ax[a].factor, avReq.writedata,
                                 avReq.byteenable);
      end
      // Clear on read, or write-one-to-clear
      if (rd && regHit(avReq.address, a, OFF_ABN)) begin
        clrA = '1;
      end else if (wr && regHit(avReq.address, a, OFF_ABN)) begin
        clrA = beMerge('0, avReq.writedata, avReq.byteenable);
      end
      if (rd && regHit(avReq.address, a, OFF_EVT)) begin
        clrE = '1;
      end else if (wr && regHit(avReq.address, a, OFF_EVT)) begin
        clrE = beMerge('0, avReq.writedata, avReq.byteenable);
      end
      // Set wins over clear in the same cycle; a bit set during a read's wait cycle is cleared unread
      d.ax[a].abn = (q.ax[a].abn & ~clrA) | setA[a];
      d.ax[a].evt = (q.ax[a].evt & ~clrE) | setE[a];
      clrA = '0;
      clrE = '0;
      pend = pend | (|axPend(q.ax[a]));
    end
    // One line, gated by the global service enable
    d.irq = q.intEn & pend;
  end

  // State register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
      q.waitReq <= 1'b1;
      for (int a = 0; a < NUM_AXES; a++) begin
        q.ax[a].posLim <= RST_LIMIT;
        q.ax[a].negLim <= RST_LIMIT;
        q.ax[a].factor <= RST_FACTOR;
        q.ax[a].abn <= RST_STATUS;
        q.ax[a].evt <= RST_STATUS;
      end
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign avReadData = q.rdata;
  assign avWaitRequest = q.waitReq;
  assign irq = q.irq;
  generate
    for (genvar g = 0; g < NUM_AXES; g++) begin : gOut
      assign stopNow[g] = q.ax[g].stopNow;
      assign stopDecel[g] = q.ax[g].stopDecel;
    end
  endgenerate

  // Checks
  property p_irqGate;
    @(posedge clk) disable iff (!rst_b)
      !q.intEn |=> !irq;
  endproperty
  a_irqGate: assert property (p_irqGate)
    else $error("interrupt raised with service disabled");

  property p_abnUnmasked;
    @(posedge clk) disable iff (!rst_b)
      q.intEn && (|q.ax[0].abn) && q.ax[0].factor == '0 |=> irq;
  endproperty
  a_abnUnmasked: assert property (p_abnUnmasked)
    else $error("abnormal status did not raise interrupt");

  property p_evtMasked;
    @(posedge clk) disable iff (!rst_b)
      q.ax[0].evt != '0 && q.ax[0].factor == '0 &&
      (q.ax[0].abn | q.ax[1].abn | q.ax[2].abn | q.ax[3].abn) == '0 &&
      (q.ax[1].evt | q.ax[2].evt | q.ax[3].evt) == '0 |=> !irq;
  endproperty
  a_evtMasked: assert property (p_evtMasked)
    else $error("masked event raised interrupt");

  property p_softStop;
    @(posedge clk) disable iff (!rst_b)
      q.ax[0].limEn && !q.ax[0].decelReact && !q.ax[0].posHit &&
      cmdPos[0] >= q.ax[0].posLim
      |=> stopNow[0] && !stopDecel[0] && q.ax[0].abn[ABN_SOFT_POS]
          && q.ax[0].evt[EVT_SOFT_POS];
  endproperty
  a_softStop: assert property (p_softStop)
    else $error("positive soft limit did not stop at once");

  property p_softDecel;
    @(posedge clk) disable iff (!rst_b)
      q.ax[1].limEn && q.ax[1].decelReact && !q.ax[1].negHit &&
      cmdPos[1] <= q.ax[1].negLim
      |=> stopDecel[1] && !stopNow[1] ##1 !stopDecel[1];
  endproperty
  a_softDecel: assert property (p_softDecel)
    else $error("negative soft limit did not request one decel");

  property p_limDisabled;
    @(posedge clk) disable iff (!rst_b)
      !q.ax[2].limEn |=> !stopNow[2] && !stopDecel[2];
  endproperty
  a_limDisabled: assert property (p_limDisabled)
    else $error("disabled soft limit stopped the axis");

  property p_readClear;
    @(posedge clk) disable iff (!rst_b)
      take && avReq.read && avReq.address == {3'd0, OFF_EVT}
      |=> (q.ax[0].evt & ~$past(setE[0])) == '0;
  endproperty
  a_readClear: assert property (p_readClear)
    else $error("event status not cleared by read");

  property p_reserved;
    @(posedge clk) disable iff (!rst_b)
      (q.ax[3].evt & ~EVT_VALID) == '0 && (q.ax[3].abn & ~ABN_VALID) == '0;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved status bit set");

  property p_latchAxes;
    @(posedge clk) disable iff (!rst_b)
      !q.ax[0].evt[EVT_LATCH] && !q.ax[1].evt[EVT_LATCH];
  endproperty
  a_latchAxes: assert property (p_latchAxes)
    else $error("latch event on an axis without latch input");

  property p_busAnswer;
    @(posedge clk) disable iff (!rst_b)
      (avReq.read | avReq.write) && avWaitRequest
      |=> !avWaitRequest ##1 avWaitRequest;
  endproperty
  a_busAnswer: assert property (p_busAnswer)
    else $error("bus answer not one cycle after request");

  c_irq: cover property (@(posedge clk) disable iff (!rst_b) $rose(irq));
  c_stop: cover property (@(posedge clk) disable iff (!rst_b)
    stopNow[0]);
  c_decel: cover property (@(posedge clk) disable iff (!rst_b)
    stopDecel[1]);
  c_clear: cover property (@(posedge clk) disable iff (!rst_b)
    irq ##[1:20] !irq);
endmodule

// >>> slis_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for asynchronous pin levels
module slis_sync import slis_pkg::*; #(
  parameter int W = 36
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } slis_sync_t;

  slis_sync_t q; // First stage feeds only the second
  slis_sync_t d;

  // Shift chain
  always_comb begin
    d.s1 = din;
    d.s2 = q.s1;
  end

  // Stage registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign dout = q.s2;
endmodule

// >>> tb_top.sv
`timescale 1ns/1ps
// Self-checking bench with an integer model of both status words
module tb_top import slis_pkg::*;;
  // Clock, reset and design ports
  logic clk, rst_b, irq;
  slis_avreq_t avReq;
  logic [31:0] avReadData, rd;
  logic avWaitRequest;
  slis_pos_t cmdPos [NUM_AXES];
  logic [31:0] coreAbn [NUM_AXES];
  logic [31:0] coreEvt [NUM_AXES];
  slis_pins_t [NUM_AXES-1:0] pinRaw;
  logic [NUM_AXES-1:0] stopNow, stopDecel;
  // Counters and model state
  int n_fail, total_checks, cyc, lim;
  int nNow [NUM_AXES], nDec [NUM_AXES], eNow [NUM_AXES], eDec [NUM_AXES];
  logic [31:0] expAbn [NUM_AXES], expEvt [NUM_AXES], fac [NUM_AXES];
  logic [31:0] sAbn [NUM_AXES], sEvt [NUM_AXES];
  logic intEn;
  logic [7:0] b;
  // Pin bit to status bit; -1 means no effect
  int pAbn [9] = '{-1, -1, -1, -1, 9, 8, 7, 6, 5};
  int pEvt [9] = '{14, 15, 19, 16, -1, -1, -1, -1, -1};

  // Free running 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  slis_soft_limit_int dut_u (.clk(clk), .rst_b(rst_b), .avReq(avReq),
    .avReadData(avReadData), .avWaitRequest(avWaitRequest),
    .cmdPos(cmdPos), .coreAbn(coreAbn), .coreEvt(coreEvt),
    .pinRaw(pinRaw), .stopNow(stopNow), .stopDecel(stopDecel), .irq(irq));

  slis_host_model host_u (.clk(clk), .avReadData(avReadData),
    .avWaitRequest(avWaitRequest), .avReq(avReq));

  // Count stop pulses mid-cycle, clear of the launching edge
  always @(negedge clk) begin
    for (int a = 0; a < NUM_AXES; a++) begin
      nNow[a] += int'(stopNow[a]);
      nDec[a] += int'(stopDecel[a]);
    end
  end

  // Hang guard, far above the planned run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      final_report();
    end
  end

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    host_u.xfer(a, 1'b1, d, rd);
  endtask

  // Model of the interrupt line
  function automatic logic expIrq();
    logic r;
    r = 1'b0;
    for (int a = 0; a < NUM_AXES; a++) begin
      r |= (expAbn[a] != 0) || ((expEvt[a] & fac[a]) != 0);
    end
    return r & intEn;
  endfunction

  // Let pin sync and irq register land, then compare the line
  task automatic settle();
    repeat (6) @(posedge clk);
    chk("irq", {31'h0, expIrq()}, {31'h0, irq});
  endtask

  // Read both words, compare, and expect them cleared by the read
  task automatic rdStat(int a);
    b = 8'(a << AXIS_SHIFT);
    host_u.xfer(b | 8'(OFF_ABN), 1'b0, '0, rd);
    chk("abnormal", expAbn[a], rd);
    host_u.xfer(b | 8'(OFF_EVT), 1'b0, '0, rd);
    chk("event", expEvt[a], rd);
    expAbn[a] = '0;
    expEvt[a] = '0;
    chk("stopNow", 32'(eNow[a]), 32'(nNow[a]));
    chk("stopDecel", 32'(eDec[a]), 32'(nDec[a]));
  endtask

  // Drive core events and pins for three cycles, then drop them
  task automatic pulse(int a, logic [31:0] ab, logic [31:0] ev,
                       slis_pins_t pn);
    @(posedge clk);
    coreAbn[a] <= ab;
    coreEvt[a] <= ev;
    pinRaw[a] <= pn;
    repeat (3) @(posedge clk);
    coreAbn[a] <= '0;
    coreEvt[a] <= '0;
    pinRaw[a] <= '0;
    expAbn[a] |= ab;
    expEvt[a] |= ev;
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Main sequence
  initial begin
    rst_b = 1'b0;
    pinRaw = '0;
    intEn = 1'b0;
    for (int a = 0; a < NUM_AXES; a++) begin
      cmdPos[a] = '0;
      coreAbn[a] = '0;
      coreEvt[a] = '0;
      expAbn[a] = '0;
      expEvt[a] = '0;
      fac[a] = '0;
    end
    void'($urandom(32'h39dd));
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    // Words are clear after reset; unmapped space reads zero
    for (int a = 0; a < NUM_AXES; a++) rdStat(a);
    host_u.xfer(8'h84, 1'b0, '0, rd);
    chk("unmapped", 32'h0, rd);
    wr(OFF_INT_EN, 32'h1);
    intEn = 1'b1;
    // Soft limits per axis; odd axes decelerate
    for (int a = 0; a < NUM_AXES; a++) begin
      b = 8'(a << AXIS_SHIFT);
      lim = int'($urandom_range(1000, 1));
      wr(b | 8'(OFF_POS_LIM), 32'(lim));
      wr(b | 8'(OFF_NEG_LIM), 32'(-lim));
      wr(b | 8'(OFF_CTRL), {30'h0, a[0], 1'b1});
      // Exactly at the limit counts as reached
      @(posedge clk) cmdPos[a] <= slis_pos_t'(lim);
      expAbn[a] = 32'h1;
      expEvt[a] = 32'h100;
      if (a[0]) eDec[a]++;
      else eNow[a]++;
      settle();
      rdStat(a);
      rdStat(a);
      settle();
      @(posedge clk) cmdPos[a] <= '0;
      @(posedge clk) cmdPos[a] <= slis_pos_t'(-lim);
      expAbn[a] = 32'h2;
      expEvt[a] = 32'h200;
      if (a[0]) eDec[a]++;
      else eNow[a]++;
      settle();
      rdStat(a);
      // Disabled: no hit, but a new limit still loads
      @(posedge clk) cmdPos[a] <= '0;
      wr(b | 8'(OFF_CTRL), 32'h0);
      wr(b | 8'(OFF_POS_LIM), 32'h5);
      @(posedge clk) cmdPos[a] <= slis_pos_t'(10);
      settle();
      rdStat(a);
      wr(b | 8'(OFF_CTRL), 32'h1);
      expAbn[a] = 32'h1;
      expEvt[a] = 32'h100;
      eNow[a]++;
      settle();
      rdStat(a);
      @(posedge clk) cmdPos[a] <= '0;
      settle();
    end
    // Masked events hold status but raise nothing; reserved bits stay 0
    pulse(1, '0, 32'hffff_ffff, '0);
    expEvt[1] = 32'h8000_1cf7;
    settle();
    rdStat(1);
    fac[1] = $urandom | 32'h1;
    wr(8'h20 | 8'(OFF_FACTOR), fac[1]);
    pulse(1, '0, 32'h1, '0);
    settle();
    host_u.service(sAbn, sEvt);
    chk("serviced", expEvt[1], sEvt[1]);
    expEvt[1] = '0;
    settle();
    // Abnormal stops ignore the mask but not the global enable
    pulse(1, 32'hffff_ffff, '0, '0);
    expAbn[1] = 32'h0003_f408;
    settle();
    wr(OFF_INT_EN, 32'h0);
    intEn = 1'b0;
    settle();
    rdStat(1);
    wr(OFF_INT_EN, 32'h1);
    intEn = 1'b1;
    // Every pin on every axis; latch only counts on axes two, three
    for (int a = 0; a < NUM_AXES; a++) begin
      for (int p = 0; p < 9; p++) begin
        pulse(a, '0, '0, slis_pins_t'(9'(1 << p)));
        if (pAbn[p] >= 0) expAbn[a][pAbn[p]] = 1'b1;
        if (pEvt[p] >= 0 && (p != 0 || a >= 2)) expEvt[a][pEvt[p]] = 1'b1;
        settle();
        rdStat(a);
      end
    end
    final_report();
  end
endmodule
